// ===== rtl/pcao_port_c_override.v
`timescale 1ns/1ps
`default_nettype none
`include "pcao_regs.vh"
module pcao_port_c_override (
   input wire clk,
   input wire resetn,
   input wire resetPinDisableFuse,
   input wire twoWireEnable,
   input wire globalPullupDisable,
   input wire changeGroup1Enable,
   input wire [6:0] pinChangeMask,
   input wire [5:0] analogDigitalInputOff,
   input wire [6:0] portDirection,
   input wire [6:0] portOutput,
   input wire [6:0] padIn,
   input wire sclDriveLow,
   input wire sdaDriveLow,
   output reg [6:0] padOut,
   output reg [6:0] padOe,
   output reg [6:0] padPullup,
   output reg [6:0] padInputEnable,
   output reg [6:0] readDirection,
   output reg [6:0] readOutput,
   output reg [6:0] readInput,
   output reg [6:0] pinChangeSource,
   output reg sclIn,
   output reg sdaIn,
   output reg externalResetPin
);
   function filt_cnt_step;
      input [`PCAO_CNT_W-1:0] cnt;
      begin
         filt_cnt_step = (cnt >= (`PCAO_FILTER_CYC - 1));
      end
   endfunction

   // Override select: an active override enable replaces the port setting
   function ovr_pick;
      input oe;
      input ov;
      input dflt;
      begin
         ovr_pick = oe ? ov : dflt;
      end
   endfunction

   reg [6:0] pullupOe, pullupOv, dirOe, dirOv, valOe, valOv, input_enable_override_enable, input_enable_override_value;
   reg [6:0] pullNext, oeNext, outNext;
   wire [6:0] pinPull, pinOe, pinOut, dieNext, digIn;
   integer i;

   always @* begin
      pullupOe = 7'h00;
      pullupOv = 7'h00;
      dirOe = 7'h00;
      dirOv = 7'h00;
      valOe = 7'h00;
      valOv = 7'h00;
      // Top pin: reset disabled forces it to input with the pull-up on unless globally disabled, not set by the port bits
      pullupOe[`PCAO_TOP] = resetPinDisableFuse;
      pullupOv[`PCAO_TOP] = 1'b1;
      dirOe[`PCAO_TOP] = resetPinDisableFuse;
      pullupOe[`PCAO_SCL] = twoWireEnable;
      pullupOe[`PCAO_SDA] = twoWireEnable;
      pullupOv[`PCAO_SCL] = portOutput[`PCAO_SCL] & ~globalPullupDisable;
      pullupOv[`PCAO_SDA] = portOutput[`PCAO_SDA] & ~globalPullupDisable;
      dirOe[`PCAO_SCL] = twoWireEnable;
      dirOe[`PCAO_SDA] = twoWireEnable;
      dirOv[`PCAO_SCL] = sclDriveLow;
      dirOv[`PCAO_SDA] = sdaDriveLow;
      valOe[`PCAO_SCL] = twoWireEnable;
      valOe[`PCAO_SDA] = twoWireEnable;
      for (i = 0; i < `PCAO_TOP; i = i + 1) begin
         input_enable_override_enable[i] = (pinChangeMask[i] & changeGroup1Enable) | analogDigitalInputOff[i];
         input_enable_override_value[i] = pinChangeMask[i] & changeGroup1Enable;
      end
      input_enable_override_enable[`PCAO_TOP] = resetPinDisableFuse |
         (pinChangeMask[`PCAO_TOP] & changeGroup1Enable);
      input_enable_override_value[`PCAO_TOP] = resetPinDisableFuse;
   end

   // Per-pin selection between override values and port register settings
   genvar p;
   generate
      for (p = 0; p < `PCAO_PINS; p = p + 1) begin : gPin
         // Plain pull-up needs input direction and output bit high
         wire portPull = ~portDirection[p] & portOutput[p] & ~globalPullupDisable;
         assign pinPull[p] = ovr_pick(pullupOe[p], pullupOv[p], portPull);
         assign pinOe[p] = ovr_pick(dirOe[p], dirOv[p], portDirection[p]);
         assign pinOut[p] = ovr_pick(valOe[p], valOv[p], portOutput[p]);
         assign dieNext[p] = ovr_pick(input_enable_override_enable[p], input_enable_override_value[p], 1'b1);
         assign digIn[p] = padIn[p] & dieNext[p];
      end
   endgenerate

   always @* begin
      pullNext = pinPull;
      oeNext = pinOe;
      outNext = pinOut;
      // Global disable also covers overridden pull-ups on the top pin
      pullNext[`PCAO_TOP] = pinPull[`PCAO_TOP] & ~globalPullupDisable;
      // Reset-pin mode: pin belongs to reset circuit, no port drive
      if (!resetPinDisableFuse) begin
         oeNext[`PCAO_TOP] = 1'b0;
         outNext[`PCAO_TOP] = 1'b0;
         pullNext[`PCAO_TOP] = 1'b1;
      end
   end

   // Spike filters on the two-wire inputs: index 0 is data, 1 is clock
   wire [1:0] twStable;
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : gFilt
         wire raw;
         reg filtLevel_reg;
         reg filtLevel_next;
         reg [`PCAO_CNT_W-1:0] filtCnt_reg;
         reg [`PCAO_CNT_W-1:0] filtCnt_next;
         assign raw = padIn[`PCAO_SDA + g];
         assign twStable[g] = filtLevel_reg;

         // A new level must hold for the whole filter time before it is taken
         always @* begin
            filtLevel_next = filtLevel_reg;
            filtCnt_next = {`PCAO_CNT_W{1'b0}};
            if (!twoWireEnable) begin
               filtLevel_next = raw;
            end else if (raw != filtLevel_reg) begin
               if (filt_cnt_step(filtCnt_reg)) begin
                  filtLevel_next = raw;
               end else begin
                  filtCnt_next = filtCnt_reg + 1'b1;
               end
            end
         end

         always @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               filtLevel_reg <= 1'b1;
               filtCnt_reg <= {`PCAO_CNT_W{1'b0}};
            end else begin
               filtLevel_reg <= filtLevel_next;
               filtCnt_reg <= filtCnt_next;
            end
         end
      end
   endgenerate

   // Pad controls take effect one cycle after the inputs
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         padOut <= 7'h00;
         padOe <= 7'h00;
         padPullup <= 7'h00;
         padInputEnable <= 7'h00;
      end else begin
         padOut <= outNext;
         padOe <= oeNext;
         padPullup <= pullNext;
         padInputEnable <= dieNext;
      end
   end

   // Top pin reads zero while it serves the reset circuit
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         readDirection <= 7'h00;
      end else begin
         readDirection <= portDirection;
         if (!resetPinDisableFuse) begin
            readDirection[`PCAO_TOP] <= 1'b0;
         end
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         readOutput <= 7'h00;
      end else begin
         readOutput <= portOutput;
         if (!resetPinDisableFuse) begin
            readOutput[`PCAO_TOP] <= 1'b0;
         end
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         readInput <= 7'h00;
      end else begin
         readInput <= digIn;
         if (!resetPinDisableFuse) begin
            readInput[`PCAO_TOP] <= 1'b0;
         end
      end
   end

   // Gated pad levels feed the change sources, bit i is source 8+i
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pinChangeSource <= 7'h00;
      end else begin
         pinChangeSource <= digIn;
      end
   end

   // Filtered lines idle high like a released bus
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sclIn <= 1'b1;
         sdaIn <= 1'b1;
      end else begin
         sclIn <= twStable[1];
         sdaIn <= twStable[0];
      end
   end

   // High means no external reset request
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         externalResetPin <= 1'b1;
      end else begin
         externalResetPin <= resetPinDisableFuse | padIn[`PCAO_TOP];
      end
   end
endmodule
`default_nettype wire

// ===== rtl/pcao_regs.vh
`ifndef PCAO_REGS_VH
`define PCAO_REGS_VH
`define PCAO_PINS 7
`define PCAO_TOP 6
`define PCAO_SCL 5
`define PCAO_SDA 4
`define PCAO_FILTER_NS 50
`define PCAO_CLK_MHZ 200
// Least time rounds up to whole cycles
`define PCAO_FILTER_CYC ((`PCAO_FILTER_NS * `PCAO_CLK_MHZ + 999) / 1000)
`define PCAO_CNT_W 4
`endif

// ===== testbench/pcao_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcao_far_model (
   input wire [6:0] padOe,
   input wire [6:0] padOut,
   input wire [6:0] extLevel,
   output wire [6:0] padIn
);
   // A driven pad shows its driver, an open one shows the far side
   assign padIn = (padOe & padOut) | (~padOe & extLevel);
endmodule
`default_nettype wire

// ===== testbench/pcao_port_c_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pcao_chk (
   input wire clk, resetn, resetPinDisableFuse, twoWireEnable, globalPullupDisable,
   input wire sclDriveLow, sdaDriveLow, sclIn, externalResetPin,
   input wire [6:0] portDirection, portOutput, padIn, padOut, padOe, padPullup,
   input wire [6:0] readDirection, readOutput, readInput
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   scl_line_a: assert property (twoWireEnable |=> !padOut[5] && padOe[5] == $past(sclDriveLow))
      else $error("scl line wrong");
   sda_line_a: assert property (twoWireEnable |=> !padOut[4] && padOe[4] == $past(sdaDriveLow))
      else $error("sda line wrong");
   plain_bits_a: assert property (1 |=> ((padOe ^ $past(portDirection)) & 7'h0f) == 7'h00)
      else $error("low bits overridden");
   pullup_off_a: assert property (globalPullupDisable |=> (padPullup & 7'h3f) == 7'h00)
      else $error("pull-up left on");
   reset_read_a: assert property (!resetPinDisableFuse |=> !(readDirection[6] | readOutput[6] | readInput[6]))
      else $error("top pin readback not zero");
   top_general_a: assert property (resetPinDisableFuse |=> externalResetPin)
      else $error("reset pin active");
   top_reset_a: assert property (!resetPinDisableFuse |=> externalResetPin == $past(padIn[6]))
      else $error("reset pin not wired");
   spike_filter_a: assert property (twoWireEnable && $past(twoWireEnable, 11) && $fell(sclIn)
      |-> $past(padIn[5], 2) == 1'b0 && $past(padIn[5], 10) == 1'b0) else $error("spike passed");
   cover property (twoWireEnable && sclDriveLow);
   cover property ($fell(sclIn));
   cover property (!resetPinDisableFuse && padIn[6]);
endmodule
bind pcao_port_c_override pcao_chk chk_u (.*);
`default_nettype wire

// ===== testbench/port_c_alt_function_override_bench.sv
`timescale 1ns/1ps
`default_nettype none
module port_c_alt_function_override_bench;
   logic clk = 0, resetn = 0, twoWireEnable = 0, resetPinDisableFuse = 0;
   logic globalPullupDisable = 0, changeGroup1Enable = 0, sclDriveLow = 0, sdaDriveLow = 0;
   logic [6:0] pinChangeMask = 0, portDirection = 0, portOutput = 0, extLevel = 7'h7f, tw, ie;
   logic [5:0] analogDigitalInputOff = 0;
   wire [6:0] padIn, padOut, padOe, padPullup, padInputEnable, pinChangeSource;
   wire [6:0] readDirection, readOutput, readInput;
   wire sclIn, sdaIn, externalResetPin;
   logic [31:0] seed = 32'hc31a_540f;
   logic [56:0] want;
   int mismatches = 0, checks = 0, cycles = 0;
   pcao_port_c_override dut_u (.*);
   pcao_far_model far_u (.*);
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) if (++cycles == 2000) begin
      mismatches++;
      test_done();
   end
   task cmp(input logic [56:0] g, input logic [56:0] w);
      checks++;
      if (g !== w) begin
         mismatches++;
         $display("[FAIL] %0t got %h want %h", $time, g, w);
      end
   endtask
   task rand_cycle(input int n);
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      {resetPinDisableFuse, globalPullupDisable, changeGroup1Enable, pinChangeMask,
         analogDigitalInputOff, portDirection, portOutput, sclDriveLow, sdaDriveLow} = seed;
      twoWireEnable = n[4];
      extLevel = seed[31:25] ^ seed[6:0];
      #1;
      tw = {7{twoWireEnable}} & 7'h30;
      ie = {resetPinDisableFuse | ~(pinChangeMask[6] & changeGroup1Enable),
         (pinChangeMask[5:0] & {6{changeGroup1Enable}}) | ~analogDigitalInputOff};
      want = {(portDirection & ~tw & 7'h3f) | (tw & {1'b0, sclDriveLow, sdaDriveLow, 4'h0}),
         portOutput & ~tw & {resetPinDisableFuse, 6'h3f},
         resetPinDisableFuse ? ~globalPullupDisable : 1'b1,
         (~portDirection[5:0] | tw[5:0]) & portOutput[5:0] & {6{~globalPullupDisable}},
         ie, padIn & ie, padIn & ie & {resetPinDisableFuse, 6'h3f},
         portDirection & {resetPinDisableFuse, 6'h3f},
         portOutput & {resetPinDisableFuse, 6'h3f}, resetPinDisableFuse | padIn[6]};
      @(negedge clk);
      cmp({padOe, padOut, padPullup, padInputEnable, pinChangeSource, readInput,
         readDirection, readOutput, externalResetPin}, want);
   endtask
   task pulse(input int b, input int n);
      extLevel[b] = 1'b0;
      repeat (n) @(negedge clk);
      cmp({56'h0, b == 5 ? sclIn : sdaIn}, {56'h0, n < 11});
      extLevel[b] = 1'b1;
      repeat (12) @(negedge clk);
      cmp({56'h0, b == 5 ? sclIn : sdaIn}, 57'h1);
   endtask
   task test_done();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge clk);
      resetn = 1;
      for (int i = 0; i < 512; i++) rand_cycle(i);
      $display("random test done");
      {twoWireEnable, sclDriveLow, sdaDriveLow, extLevel} = {3'b100, 7'h7f};
      repeat (14) @(negedge clk);
      pulse(5, 9);
      pulse(5, 11);
      pulse(4, 9);
      pulse(4, 11);
      $display("filter test done");
      test_done();
   end
endmodule
`default_nettype wire
